// file: hdl/pbs_defs.svh
`ifndef PBS_DEFS_SVH
`define PBS_DEFS_SVH

`define PBS_ADDR_W     17
`define PBS_LANES      4
`define PBS_LANE_W     8
`define PBS_DATA_W     32
`define PBS_WORD_W     36
`define PBS_PARITY_LSB 32
`define PBS_SLEEP_CYC  2
`define PBS_BURST_LEN  4

`endif

// file: hdl/pbs_pkg.sv
package pbs_pkg;

   typedef enum logic [3:0] {
      PBS_AWAKE  = 4'h1,
      PBS_ENTER  = 4'h2,
      PBS_ASLEEP = 4'h4,
      PBS_WAKE   = 4'h8
   } pbs_sleep_e;

   typedef enum logic [2:0] {
      PBS_OP_DESELECT = 3'h0,
      PBS_OP_READ     = 3'h1,
      PBS_OP_WRITE    = 3'h2,
      PBS_OP_ABORT    = 3'h3,
      PBS_OP_STALL    = 3'h4,
      PBS_OP_SNOOZE   = 3'h5
   } pbs_op_e;

endpackage

// file: hdl/pbs_sram.sv
`timescale 1ns/1ps
`default_nettype none
`include "pbs_defs.svh"

module pbs_sram
   import pbs_pkg::*;
#(
   parameter int ADDR_W = `PBS_ADDR_W
) (
   input  wire logic                    clk,
   input  wire logic                    reset_n,
   input  wire logic [ADDR_W-1:0]       addr,
   input  wire logic                    chip_sel1_n,
   input  wire logic                    chip_sel2,
   input  wire logic                    chip_sel3_n,
   input  wire logic                    advance_or_load,
   input  wire logic                    write_n,
   input  wire logic [`PBS_LANES-1:0]   byte_lane_write_n,
   input  wire logic                    out_enable_n,
   input  wire logic                    clock_qualify_n,
   input  wire logic                    sleep_request,
   input  wire logic                    burst_order,
   input  wire logic [`PBS_DATA_W-1:0]  data_i,
   output logic      [`PBS_DATA_W-1:0]  data_o,
   output logic                         data_oe,
   input  wire logic [`PBS_LANES-1:0]   parity_lines_i,
   output logic      [`PBS_LANES-1:0]   parity_lines_o,
   output logic                         parity_lines_oe,
   output var pbs_op_e                  cycle_op
);

   localparam int DEPTH = 1 << ADDR_W;

   // merge selected lanes of a new word over an old one
   function automatic logic [`PBS_WORD_W-1:0] lane_merge(
      input logic [`PBS_WORD_W-1:0] old_w,
      input logic [`PBS_WORD_W-1:0] new_w,
      input logic [`PBS_LANES-1:0]  be);
      logic [`PBS_WORD_W-1:0] r;
      r = old_w;
      for (int b = 0; b < `PBS_LANES; b++) begin
         if (be[b]) begin
            r[b*`PBS_LANE_W +: `PBS_LANE_W] = new_w[b*`PBS_LANE_W +: `PBS_LANE_W];
            r[`PBS_PARITY_LSB + b] = new_w[`PBS_PARITY_LSB + b];
         end
      end
      return r;
   endfunction

   // next burst offset of the low address bits
   function automatic logic [1:0] burst_step(
      input logic [1:0] base,
      input logic [1:0] cnt,
      input logic       interleave);
      return interleave ? (base ^ cnt) : (base + cnt);
   endfunction

   logic [`PBS_WORD_W-1:0] mem [0:DEPTH-1];

   pbs_sleep_e          sleep_st;
   logic [1:0]          sleep_cnt;
   logic                burst_active;
   logic                burst_write;
   logic [ADDR_W-1:0]   burst_base;
   logic [1:0]          burst_cnt;
   logic                s1_valid;
   logic                s1_write;
   logic [ADDR_W-1:0]   s1_addr;
   logic [`PBS_LANES-1:0] s1_be;
   logic                s2_read;
   logic                s2_write;
   logic [ADDR_W-1:0]   s2_addr;
   logic [`PBS_LANES-1:0] s2_be;

   logic                awake;
   logic                qual;
   logic                sel;
   logic                load;
   logic                adv;
   logic                no_lane;
   logic [1:0]          next_cnt;
   logic [ADDR_W-1:0]   next_addr;
   pbs_op_e             next_op;
   logic [`PBS_WORD_W-1:0] bus_word;
   logic [`PBS_WORD_W-1:0] rd_word;

   assign awake    = (sleep_st == PBS_AWAKE) && !sleep_request;
   assign qual     = awake && !clock_qualify_n;
   assign sel      = !chip_sel1_n && chip_sel2 && !chip_sel3_n;
   assign load     = qual && !advance_or_load;
   assign adv      = qual && advance_or_load;
   assign no_lane  = &byte_lane_write_n;
   assign next_cnt = burst_cnt + 2'h1;
   assign bus_word = {parity_lines_i, data_i};

   // cycle decode
   always_comb begin
      next_addr = addr;
      if (!awake) begin
         next_op = PBS_OP_SNOOZE;
      end else if (clock_qualify_n) begin
         next_op = PBS_OP_STALL;
      end else if (load) begin
         if (!sel) begin
            next_op = PBS_OP_DESELECT;
         end else if (write_n) begin
            next_op = PBS_OP_READ;
         end else if (no_lane) begin
            next_op = PBS_OP_ABORT;
         end else begin
            next_op = PBS_OP_WRITE;
         end
      end else begin
         next_addr = {burst_base[ADDR_W-1:2], burst_step(burst_base[1:0], next_cnt,
                      burst_order)};
         if (!burst_active) begin
            next_op = PBS_OP_DESELECT;
         end else if (!burst_write) begin
            next_op = PBS_OP_READ;
         end else if (no_lane) begin
            next_op = PBS_OP_ABORT;
         end else begin
            next_op = PBS_OP_WRITE;
         end
      end
   end

   // sleep entry and exit sequencing
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sleep_st  <= PBS_AWAKE;
         sleep_cnt <= 2'h0;
      end else begin
         case (sleep_st)
            PBS_AWAKE: begin
               if (sleep_request) begin
                  sleep_st  <= PBS_ENTER;
                  sleep_cnt <= 2'h1;
               end
            end
            PBS_ENTER: begin
               if (!sleep_request) begin
                  sleep_st  <= PBS_WAKE;
                  sleep_cnt <= 2'h1;
               end else if (sleep_cnt == 2'(`PBS_SLEEP_CYC - 1)) begin
                  sleep_st <= PBS_ASLEEP;
               end else begin
                  sleep_cnt <= sleep_cnt + 2'h1;
               end
            end
            PBS_ASLEEP: begin
               if (!sleep_request) begin
                  sleep_st  <= PBS_WAKE;
                  sleep_cnt <= 2'h1;
               end
            end
            PBS_WAKE: begin
               if (sleep_request) begin
                  sleep_st  <= PBS_ENTER;
                  sleep_cnt <= 2'h1;
               end else if (sleep_cnt == 2'(`PBS_SLEEP_CYC - 1)) begin
                  sleep_st <= PBS_AWAKE;
               end else begin
                  sleep_cnt <= sleep_cnt + 2'h1;
               end
            end
            default: begin
               sleep_st  <= PBS_AWAKE;
               sleep_cnt <= 2'h0;
            end
         endcase
      end
   end

   // burst tracking; the access type is frozen at the load edge
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         burst_active <= 1'b0;
         burst_write  <= 1'b0;
         burst_base   <= '0;
         burst_cnt    <= 2'h0;
      end else if (!awake) begin
         burst_active <= 1'b0; // pending bursts are dropped on sleep
      end else if (load) begin
         burst_active <= sel;
         burst_write  <= !write_n;
         burst_base   <= addr;
         burst_cnt    <= 2'h0;
      end else if (adv && burst_active) begin
         burst_cnt <= next_cnt;
      end
   end

   // stage one: accepted access
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s1_valid <= 1'b0;
         s1_write <= 1'b0;
         s1_addr  <= '0;
         s1_be    <= '0;
      end else if (!awake) begin
         s1_valid <= 1'b0;
      end else if (qual) begin
         s1_valid <= (next_op == PBS_OP_READ) || (next_op == PBS_OP_WRITE);
         s1_write <= (next_op == PBS_OP_WRITE);
         s1_addr  <= next_addr;
         s1_be    <= ~byte_lane_write_n;
      end
   end

   // a read right behind a write to the same word sees the write
   always_comb begin
      rd_word = mem[s1_addr];
      if (s2_write && s2_addr == s1_addr) begin
         rd_word = lane_merge(rd_word, bus_word, s2_be);
      end
   end

   // stage two: data slot
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s2_read        <= 1'b0;
         s2_write       <= 1'b0;
         s2_addr        <= '0;
         s2_be          <= '0;
         data_o         <= '0;
         parity_lines_o <= '0;
      end else if (!awake) begin
         s2_read  <= 1'b0;
         s2_write <= 1'b0;
      end else if (qual) begin
         s2_read  <= s1_valid && !s1_write;
         s2_write <= s1_valid && s1_write;
         s2_addr  <= s1_addr;
         s2_be    <= s1_be;
         if (s1_valid && !s1_write) begin
            data_o         <= rd_word[`PBS_DATA_W-1:0];
            parity_lines_o <= rd_word[`PBS_WORD_W-1:`PBS_PARITY_LSB];
         end
      end
   end

   // array write; no reset so the contents survive sleep and reset
   always_ff @(posedge clk) begin
      if (qual && s2_write) begin
         mem[s2_addr] <= lane_merge(mem[s2_addr], bus_word, s2_be);
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cycle_op <= PBS_OP_DESELECT;
      end else begin
         cycle_op <= next_op;
      end
   end

   // output enable is never registered so it can float the bus at once
   assign data_oe         = s2_read && !out_enable_n && awake;
   assign parity_lines_oe = data_oe;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   property p_powerup;
      $past(!reset_n) |-> !data_oe && !parity_lines_oe;
   endproperty
   a_powerup: assert property (p_powerup) else $error("drivers on after reset");

   property p_deselect;
      load && !sel |=> !s1_valid && !burst_active;
   endproperty
   a_deselect: assert property (p_deselect) else $error("unselected load began access");

   property p_read_start;
      load && sel && write_n |=> s1_valid && !s1_write && s1_addr == $past(addr);
   endproperty
   a_read_start: assert property (p_read_start) else $error("read start wrong");

   property p_read_cont;
      adv && burst_active && !burst_write |=> s1_valid && !s1_write;
   endproperty
   a_read_cont: assert property (p_read_cont) else $error("read continue wrong");

   property p_dummy;
      s2_read && out_enable_n |-> !data_oe;
   endproperty
   a_dummy: assert property (p_dummy) else $error("dummy read drove bus");

   property p_write_start;
      load && sel && !write_n && !no_lane |=> s1_valid && s1_write && s1_addr == $past(addr);
   endproperty
   a_write_start: assert property (p_write_start) else $error("write start wrong");

   // continuing beats keep the write type even with the selects dropped
   property p_write_cont;
      adv && burst_active && burst_write && !no_lane |=> s1_valid && s1_write;
   endproperty
   a_write_cont: assert property (p_write_cont) else $error("write continue wrong");

   property p_abort;
      load && sel && !write_n && no_lane |=> !s1_valid;
   endproperty
   a_abort: assert property (p_abort) else $error("abort used an address");

   property p_abort_cont;
      adv && burst_active && burst_write && no_lane
         |=> !s1_valid && burst_cnt == $past(burst_cnt) + 2'h1;
   endproperty
   a_abort_cont: assert property (p_abort_cont) else $error("abort did not advance");

   property p_stall;
      awake && clock_qualify_n
         |=> $stable(burst_cnt) && $stable(s1_valid) && $stable(s2_write) && $stable(data_o);
   endproperty
   a_stall: assert property (p_stall) else $error("stalled edge changed state");

   property p_wmask;
      s2_write |-> !data_oe && !parity_lines_oe;
   endproperty
   a_wmask: assert property (p_wmask) else $error("drivers on in write");

   property p_sleep;
      sleep_request && sleep_st == PBS_AWAKE ##1 sleep_request |=> sleep_st == PBS_ASLEEP;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep entry not two cycles");

   property p_linear;
      adv && burst_active && !burst_order
         |=> s1_addr[1:0] == $past(burst_base[1:0]) + $past(burst_cnt) + 2'h1;
   endproperty
   a_linear: assert property (p_linear) else $error("linear step wrong");

   property p_type_kept;
      adv && burst_active |=> burst_write == $past(burst_write);
   endproperty
   a_type_kept: assert property (p_type_kept) else $error("burst type changed");

   property p_data_slot;
      qual && s1_valid && s1_write |=> s2_write && s2_addr == $past(s1_addr);
   endproperty
   a_data_slot: assert property (p_data_slot) else $error("write slot misplaced");

endmodule // pbs_sram

`default_nettype wire

// file: tb/pbs_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none

module pbs_ctrl_model (
   input  wire logic        clk,
   input  wire logic        clock_qualify_n,
   input  wire logic        sleep_request,
   input  wire logic        sel,
   input  wire logic        advance_or_load,
   input  wire logic        write_n,
   input  wire logic [35:0] word,
   input  wire logic [35:0] dev_word,
   input  wire logic        dev_oe,
   output logic      [35:0] bus,
   output logic             drive
);
   logic        in_wr = 1'h0;
   logic        pend  = 1'h0;
   logic        act   = 1'h0;
   logic [35:0] held  = 36'h0_0000_0000;
   logic [35:0] last  = 36'h0_0000_0000;

   // the model holds its state, drive included, while sleep is requested or on an ignored edge
   always @(posedge clk) begin
      if (!clock_qualify_n && !sleep_request) begin
         if (!advance_or_load) begin
            in_wr <= sel && !write_n;
         end
         pend <= advance_or_load ? in_wr : sel && !write_n;
         held <= word;
         act  <= pend;
         if (pend) begin
            last <= held;
         end
      end
   end

   assign drive = act;
   // released bus shows the inverse of the last word so a stale copy never matches
   assign bus = dev_oe ? dev_word : act ? last : ~last;
endmodule // pbs_ctrl_model

`default_nettype wire

// file: tb/pipelined_burst_sram_cycle_decode_tb.sv
`timescale 1ns/1ps
`default_nettype none

module pipelined_burst_sram_cycle_decode_tb
   import pbs_pkg::*;
;
   localparam logic [16:0] LA = 17'h0_0200;
   localparam logic [16:0] LB = 17'h0_0101;
   logic        clk = 1'h0;
   logic        reset_n = 1'h0;
   logic [16:0] addr = 17'h0_0000;
   logic        chip_sel1_n = 1'h1;
   logic        chip_sel2 = 1'h0;
   logic        chip_sel3_n = 1'h1;
   logic        advance_or_load = 1'h0;
   logic        write_n = 1'h1;
   logic [3:0]  byte_lane_write_n = 4'hf;
   logic        out_enable_n = 1'h0;
   logic        clock_qualify_n = 1'h0;
   logic        sleep_request = 1'h0;
   logic        burst_order = 1'h0;
   logic [35:0] word = 36'h0_0000_0000;
   logic [35:0] bus;
   logic [31:0] data_o;
   logic [3:0]  par_o;
   logic        data_oe;
   logic        par_oe;
   logic        drive;
   logic        ck;
   pbs_op_e     cycle_op;
   pbs_op_e     eo;
   pbs_op_e     op_n = PBS_OP_DESELECT;
   logic        op_ck = 1'h1;
   int          error_cnt = 0;
   int          tests_run = 0;
   logic [35:0] mem [int];
   logic [35:0] eq [$];
   logic [35:0] rq [$];

   always #25 clk = ~clk;

   pbs_sram i_dut (
      .clk(clk), .reset_n(reset_n), .addr(addr), .chip_sel1_n(chip_sel1_n),
      .chip_sel2(chip_sel2), .chip_sel3_n(chip_sel3_n), .advance_or_load(advance_or_load),
      .write_n(write_n), .byte_lane_write_n(byte_lane_write_n), .out_enable_n(out_enable_n),
      .clock_qualify_n(clock_qualify_n), .sleep_request(sleep_request),
      .burst_order(burst_order), .data_i(bus[31:0]), .data_o(data_o), .data_oe(data_oe),
      .parity_lines_i(bus[35:32]), .parity_lines_o(par_o), .parity_lines_oe(par_oe),
      .cycle_op(cycle_op));

   pbs_ctrl_model i_ctrl (
      .clk(clk), .clock_qualify_n(clock_qualify_n), .sleep_request(sleep_request),
      .sel(!chip_sel1_n && chip_sel2 && !chip_sel3_n), .advance_or_load(advance_or_load),
      .write_n(write_n), .word(word), .dev_word({par_o, data_o}), .dev_oe(data_oe),
      .bus(bus), .drive(drive));

   task automatic chk(input logic [35:0] g, input logic [35:0] e);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value at %0t ns: got %h expected %h", $time, g, e);
      end
   endtask

   // read words are collected only on edges the device really takes
   always @(posedge clk) begin
      eo = op_n;
      ck = op_ck;
      if (data_oe === 1'h1 && !clock_qualify_n) begin
         rq.push_back({par_o, data_o});
      end
      chk(36'(data_oe & drive), 36'h0_0000_0000);
      chk(36'(par_oe), 36'(data_oe));
      chk(36'(data_oe & out_enable_n), 36'h0_0000_0000);
      #1;
      if (ck) begin
         chk(36'(cycle_op), 36'(eo));
      end
   end

   function automatic logic [16:0] nxt(input logic [16:0] b, input int i, input logic o);
      nxt = {b[16:2], o ? b[1:0] ^ 2'(i) : b[1:0] + 2'(i)};
   endfunction

   function automatic logic [35:0] wv(input int k);
      wv = {k[3:0], ~k[7:0], 8'(k * 3), 8'(k + 90), k[7:0]};
   endfunction

   function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] n,
                                         input logic [3:0] ln);
      merge = o;
      for (int b = 0; b < 4; b++) begin
         if (!ln[b]) begin
            merge[8*b +: 8] = n[8*b +: 8];
            merge[32+b] = n[32+b];
         end
      end
   endfunction

   task automatic cmd(input logic s, input logic ld, input logic wn, input logic [3:0] ln,
                      input logic [16:0] a, input logic [35:0] w, input pbs_op_e op);
      @(posedge clk);
      chip_sel1_n <= !s;
      chip_sel2 <= s;
      chip_sel3_n <= !s;
      advance_or_load <= !ld;
      write_n <= wn;
      byte_lane_write_n <= ln;
      addr <= a;
      word <= w;
      clock_qualify_n <= 1'h0;
      op_n <= op;
   endtask

   task automatic idle(input int n);
      repeat (n) cmd(0, 1, 1, 4'hf, 17'h1_ffff, 36'h0_0000_0000, PBS_OP_DESELECT);
   endtask

   // advance beats drop the selects and flip the strobe: both must be ignored
   task automatic wr(input logic ld, input logic [3:0] ln, input logic [16:0] a,
                     input logic [35:0] w);
      mem[a] = merge(mem[a], w, ln);
      cmd(ld, ld, !ld, ln, ld ? a : ~a, w, ln == 4'hf ? PBS_OP_ABORT : PBS_OP_WRITE);
   endtask

   // enable is looked at after the edge so a change made just before the call counts
   task automatic rd(input logic ld, input logic [16:0] a);
      cmd(ld, ld, ld, 4'h0, ld ? a : ~a, 36'h0_0000_0000, PBS_OP_READ);
      if (!out_enable_n) begin
         eq.push_back(mem[a]);
      end
   endtask

   task automatic drain(input string name);
      idle(4);
      chk(36'(rq.size()), 36'(eq.size()));
      foreach (eq[i]) begin
         if (i < rq.size()) begin
            chk(rq[i], eq[i]);
         end
      end
      rq.delete();
      eq.delete();
      $display("test %s done", name);
   endtask

   task automatic t_burst();
      for (int o = 0; o < 2; o++) begin
         burst_order <= o[0];
         for (int i = 0; i < 4; i++) wr(i == 0, 4'h0, nxt(LB, i, o[0]), wv(i + 4 * o));
         for (int i = 0; i < 4; i++) rd(1, nxt(LB, 3 - i, o[0]));
         for (int i = 0; i < 4; i++) rd(i == 0, nxt(LB, i, o[0]));
         drain("burst");
      end
   endtask

   task automatic t_lanes();
      wr(1, 4'h0, LA, wv(100));
      for (int l = 0; l < 16; l++) begin
         wr(1, 4'(l), LA, wv(l + 16));
         rd(1, LA);
      end
      wr(1, 4'h0, LA + 5, wv(40));
      wr(1, 4'h0, LA + 4, wv(41));
      wr(0, 4'hf, LA + 5, wv(42));
      wr(0, 4'h0, LA + 6, wv(43));
      cmd(0, 1, 0, 4'h0, LA, wv(99), PBS_OP_DESELECT);
      for (int i = 0; i < 3; i++) rd(1, LA + 4 + i);
      rd(1, LA);
      drain("lanes");
   endtask

   task automatic t_oe();
      out_enable_n <= 1'h1;
      rd(1, LA);
      rd(0, LA + 1);
      drain("dummy");
      out_enable_n <= 1'h0;
      rd(1, LA);
      rd(1, LA);
      idle(1);
      // first word is hidden by the enable alone, with no edge in between
      out_enable_n <= 1'h1;
      #1 chk(36'(data_oe), 36'h0_0000_0000);
      eq.delete(0);
      idle(1);
      out_enable_n <= 1'h0;
      #1 chk(36'(data_oe), 36'h0_0000_0001);
      drain("enable");
   endtask

   task automatic t_stall();
      rd(1, LB);
      rd(0, nxt(LB, 1, 1));
      repeat (3) begin
         @(posedge clk);
         clock_qualify_n <= 1'h1;
         op_n <= PBS_OP_STALL;
         advance_or_load <= 1'h0;
         write_n <= 1'h0;
         chip_sel1_n <= 1'h0;
         chip_sel2 <= 1'h1;
         chip_sel3_n <= 1'h0;
         addr <= LB;
      end
      rd(0, nxt(LB, 2, 1));
      rd(0, nxt(LB, 3, 1));
      rd(1, LB);
      drain("stall");
   endtask

   task automatic t_sleep();
      op_ck <= 1'h0;
      sleep_request <= 1'h1;
      idle(2);
      repeat (3) cmd(1, 1, 0, 4'h0, LA, wv(55), PBS_OP_SNOOZE);
      #1 chk(36'(cycle_op), 36'(PBS_OP_SNOOZE));
      idle(1);
      sleep_request <= 1'h0;
      idle(3);
      op_ck <= 1'h1;
      rd(1, LA);
      drain("sleep");
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // the whole run needs about 120 cycles; this is far beyond it
   initial begin
      #100000;
      error_cnt++;
      conclude();
   end

   initial begin
      @(negedge clk);
      chk(36'(data_oe), 36'h0_0000_0000);
      repeat (2) @(posedge clk);
      reset_n <= 1'h1;
      t_burst();
      t_lanes();
      t_oe();
      t_stall();
      t_sleep();
      conclude();
   end
endmodule // pipelined_burst_sram_cycle_decode_tb

`default_nettype wire
